// File: design/mmd_decoder.v
// Address decoder and target steering for the unified 16 Mbyte map
//
// Operation
// - One linear 16 Mbyte space; byte and word access everywhere.
// - Bootstrap maps 4K test sector at 00'0000h; hidden in user mode.
// - User mode: 12 flash sectors, 8K x4, 32K, 64K x7.
// - Sector 10/11 status duplicated as second-bank sectors 0 and 1.
// - 0E'0000h-0E'FFFFh reaches flash controls only when window enabled.
// - No program or erase while flash control window is disabled.
// - Flash control accesses: 16-bit demuxed, no delay, byte or word.
// - 2K dual-port internal RAM; banks of 16 word or byte registers.
// - Low 2K and high 32K extension RAM, zero wait, byte or word.
// - Low extension RAM at 00'E000h only with both enables set.
// - Low area disabled: access goes external via matching window set.
// - High 32K extension RAM at 0F'0000h with both enables set.
// - Global enable clear: high area range goes external.
// - A unit disabled at global enable claims no address space.
// - Extension RAM never used as stack, banks or bit access.
`timescale 1ns/1ns
`include "mmd_defs.vh"

module mmd_decoder
#(
  parameter NUM_WIN = 4
)
(
  // Clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  // CPU request
  input wire cpu_req_in,
  input wire [`MMD_AW-1:0] cpu_addr_in,
  input wire cpu_wr_in,
  input wire cpu_byte_in,
  input wire cpu_fetch_in,
  input wire cpu_stack_in,
  input wire cpu_bitop_in,
  input wire [`MMD_DW-1:0] cpu_wdata_in,
  // Register bank access
  input wire gpr_in,
  input wire [3:0] gpr_idx_in,
  input wire [`MMD_AW-1:0] ctx_ptr_in,
  // Configuration
  input wire bootstrap_mode_in,
  input wire global_periph_bus_enable_in,
  input wire low_ext_ram_enable_in,
  input wire high_ext_ram_enable_in,
  input wire flash_ctrl_window_enable_in,
  input wire flash_write_busy_in,
  input wire [`MMD_NUM_SECTORS-1:0] flash_sector_status_in,
  // Address select windows
  input wire [NUM_WIN-1:0] win_en_in,
  input wire [NUM_WIN*`MMD_WIN_W-1:0] win_lo_in,
  input wire [NUM_WIN*`MMD_WIN_W-1:0] win_hi_in,
  // Target side
  output reg tgt_valid_out,
  output reg [2:0] tgt_sel_out,
  output reg [`MMD_AW-1:0] tgt_addr_out,
  output reg tgt_wr_out,
  output reg tgt_byte_out,
  output reg [`MMD_DW-1:0] tgt_wdata_out,
  output reg tgt_demux16_out,
  output reg [3:0] sector_out,
  output reg bank1_alias_out,
  output reg bank1_sector_out,
  output reg [2:0] ext_cfg_set_out,
  // Status
  output reg pe_enable_out,
  output reg [1:0] second_bank_status_out,
  output reg rww_violation_out,
  output reg xram_misuse_out
);

  // ---------------------------------------------------------------
  // Effective address
  // ---------------------------------------------------------------
  reg [`MMD_AW-1:0] eff_addr;

  always @*
  begin
    eff_addr = cpu_addr_in;
    if (gpr_in)
    begin
      // Word regs sit two bytes apart; byte halves RLn/RHn step by one
      if (cpu_byte_in)
        eff_addr = ctx_ptr_in + {20'h00000, gpr_idx_in};
      else
        eff_addr = ctx_ptr_in + {19'h00000, gpr_idx_in, 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Region hits
  // ---------------------------------------------------------------
  wire flash_hit;
  wire [3:0] flash_sector;

  mmd_sector_map u_sector_map
  (
    .addr_in(eff_addr),
    .hit_out(flash_hit),
    .sector_out(flash_sector)
  );

  wire test_hit;
  wire freg_hit;
  wire internal_dual_port_ram_hit;
  wire xlow_range;
  wire xhigh_range;
  wire xlow_on;
  wire xhigh_on;

  // Test sector only in bootstrap mode
  assign test_hit = bootstrap_mode_in && (eff_addr[23:12] == `MMD_TEST_PAGE);
  // Control window gated by its enable
  assign freg_hit = flash_ctrl_window_enable_in && (eff_addr[23:16] == `MMD_FREG_SEG);
  assign internal_dual_port_ram_hit = (eff_addr[23:11] == `MMD_INTERNAL_DUAL_PORT_RAM_PAGE);
  assign xlow_range = (eff_addr[23:11] == `MMD_XLOW_PAGE);
  assign xhigh_range = (eff_addr[23:15] == `MMD_XHIGH_PAGE);
  // Both enables needed for the low area
  assign xlow_on = global_periph_bus_enable_in && low_ext_ram_enable_in;
  // Both enables needed for the high area
  assign xhigh_on = global_periph_bus_enable_in && high_ext_ram_enable_in;

  // ---------------------------------------------------------------
  // Address select window match
  // ---------------------------------------------------------------
  wire [NUM_WIN-1:0] win_match;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi = gi + 1)
    begin : g_win
      wire [`MMD_WIN_W-1:0] lo;
      wire [`MMD_WIN_W-1:0] hi;
      assign lo = win_lo_in[gi*`MMD_WIN_W +: `MMD_WIN_W];
      assign hi = win_hi_in[gi*`MMD_WIN_W +: `MMD_WIN_W];
      assign win_match[gi] = win_en_in[gi] && (eff_addr[23:12] >= lo) &&
                             (eff_addr[23:12] <= hi);
    end
  endgenerate

  // Lowest matching window wins; no match uses the default set
  reg [2:0] cfg_set;
  integer wi;

  always @*
  begin
    cfg_set = `MMD_CFG_DEFAULT;
    for (wi = NUM_WIN - 1; wi >= 0; wi = wi - 1)
    begin
      if (win_match[wi])
        cfg_set = wi[2:0] + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Target selection
  // ---------------------------------------------------------------
  reg [2:0] sel;
  reg misuse;

  always @*
  begin
    misuse = 1'b0;
    // Test sector overrides user sectors in bootstrap mode
    if (test_hit)
      sel = `MMD_TGT_TEST;
    else if (flash_hit)
      sel = `MMD_TGT_FLASH;
    else if (freg_hit)
      sel = `MMD_TGT_FREG;
    else if (internal_dual_port_ram_hit)
      sel = `MMD_TGT_INTERNAL_DUAL_PORT_RAM;
    else if (xlow_range && xlow_on)
      sel = `MMD_TGT_XLOW;
    else if (xhigh_range && xhigh_on)
      sel = `MMD_TGT_XHIGH;
    else
      sel = `MMD_TGT_EXT;
    // Stack, bank or bit access to extension RAM is dropped
    if (((sel == `MMD_TGT_XLOW) || (sel == `MMD_TGT_XHIGH)) &&
        (cpu_stack_in || cpu_bitop_in || gpr_in))
    begin
      misuse = 1'b1;
      sel = `MMD_TGT_NONE;
    end
  end

  wire on_chip_demux;
  // Extension RAM and control window run 16-bit demuxed
  assign on_chip_demux = (sel == `MMD_TGT_FREG) || (sel == `MMD_TGT_XLOW) ||
                         (sel == `MMD_TGT_XHIGH);

  // ---------------------------------------------------------------
  // Next values of pulses and flash tags
  // ---------------------------------------------------------------
  reg valid_nxt;
  reg misuse_nxt;
  reg flash_read_nxt;
  reg rww_nxt;
  reg alias_nxt;
  reg alias_hi_nxt;

  always @*
  begin
    valid_nxt = cpu_req_in && !misuse;
    misuse_nxt = cpu_req_in && misuse;
    // Fetches count as reads of the array
    flash_read_nxt = (cpu_fetch_in || !cpu_wr_in) &&
                     ((sel == `MMD_TGT_FLASH) || (sel == `MMD_TGT_TEST));
    // Only reported: stalling the master here would hide the software fault
    // Read during write
    rww_nxt = cpu_req_in && flash_write_busy_in && flash_read_nxt;
    alias_nxt = (sel == `MMD_TGT_FLASH) &&
                ((flash_sector == `MMD_SEC_TEN) || (flash_sector == `MMD_SEC_ELEVEN));
    alias_hi_nxt = (flash_sector == `MMD_SEC_ELEVEN);
  end

  // ---------------------------------------------------------------
  // Registered levels
  // ---------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pe_enable_out <= 1'b0;
      second_bank_status_out <= 2'h0;
    end
    else
    begin
      // Program/erase allowed only with the window enabled
      pe_enable_out <= flash_ctrl_window_enable_in;
      // Duplicate sector 10/11 status as second bank
      second_bank_status_out <= flash_sector_status_in[`MMD_NUM_SECTORS-1 -: 2];
    end
  end

  // ---------------------------------------------------------------
  // Registered pulses
  // ---------------------------------------------------------------
  // Rebuilt every cycle, so an idle cycle clears them
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tgt_valid_out <= 1'b0;
      xram_misuse_out <= 1'b0;
      rww_violation_out <= 1'b0;
    end
    else
    begin
      tgt_valid_out <= valid_nxt;
      xram_misuse_out <= misuse_nxt;
      rww_violation_out <= rww_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Registered target side
  // ---------------------------------------------------------------
  // Held until the next request so a slow target can keep sampling it
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tgt_sel_out <= `MMD_TGT_NONE;
      tgt_addr_out <= 24'h000000;
      tgt_wr_out <= 1'b0;
      tgt_byte_out <= 1'b0;
      tgt_wdata_out <= 16'h0000;
      tgt_demux16_out <= 1'b0;
      sector_out <= 4'h0;
      bank1_alias_out <= 1'b0;
      bank1_sector_out <= 1'b0;
      ext_cfg_set_out <= `MMD_CFG_DEFAULT;
    end
    else if (cpu_req_in)
    begin
      // Address and size pass through for every target
      tgt_sel_out <= sel;
      tgt_addr_out <= eff_addr;
      tgt_wr_out <= cpu_wr_in;
      tgt_byte_out <= cpu_byte_in;
      tgt_wdata_out <= cpu_wdata_in;
      tgt_demux16_out <= on_chip_demux;
      sector_out <= flash_sector;
      // Sectors 10 and 11 also answer as second-bank 0 and 1
      bank1_alias_out <= alias_nxt;
      bank1_sector_out <= alias_hi_nxt;
      // Bus set from the matching window
      ext_cfg_set_out <= cfg_set;
    end
  end

endmodule

// File: design/mmd_sector_map.v
// Flash sector lookup for a 24-bit address
`timescale 1ns/1ns
`include "mmd_defs.vh"

module mmd_sector_map
(
  // Address
  input wire [`MMD_AW-1:0] addr_in,
  // Result
  output reg hit_out,
  output reg [3:0] sector_out
);

  wire [7:0] seg;
  assign seg = addr_in[23:16];

  always @*
  begin
    hit_out = 1'b0;
    sector_out = 4'h0;
    if ((seg == `MMD_SEG_SMALL) && !addr_in[15])
    begin
      hit_out = 1'b1;
      sector_out = {2'b00, addr_in[14:13]};
    end
    else if ((seg == `MMD_SEG_S4) && addr_in[15])
    begin
      hit_out = 1'b1;
      sector_out = `MMD_SEC_S4;
    end
    else if ((seg >= `MMD_SEG_FIRST64) && (seg <= `MMD_SEG_LAST64))
    begin
      hit_out = 1'b1;
      sector_out = addr_in[19:16] + `MMD_SEC_BASE64;
    end
  end

endmodule

// File: shared/mmd_defs.vh
// Constants for the memory map decoder
`ifndef MMD_DEFS_VH
`define MMD_DEFS_VH

// ---------------------------------------------------------------
// Address space
// ---------------------------------------------------------------
`define MMD_AW 24
`define MMD_DW 16

// ---------------------------------------------------------------
// Target codes
// ---------------------------------------------------------------
`define MMD_TGT_FLASH 3'h0
`define MMD_TGT_TEST 3'h1
`define MMD_TGT_FREG 3'h2
`define MMD_TGT_INTERNAL_DUAL_PORT_RAM 3'h3
`define MMD_TGT_XLOW 3'h4
`define MMD_TGT_XHIGH 3'h5
`define MMD_TGT_EXT 3'h6
`define MMD_TGT_NONE 3'h7

// ---------------------------------------------------------------
// Region matches (upper address bits)
// ---------------------------------------------------------------
// Test sector 4 Kbyte at 00'0000h: addr[23:12]
`define MMD_TEST_PAGE 12'h000
// Flash control window 0E'0000h-0E'FFFFh: addr[23:16]
`define MMD_FREG_SEG 8'h0E
// Internal RAM 2 Kbyte: addr[23:11]
`define MMD_INTERNAL_DUAL_PORT_RAM_PAGE 13'h001E
// Low extension RAM 00'E000h-00'E7FFh: addr[23:11]
`define MMD_XLOW_PAGE 13'h001C
// High extension RAM from 0F'0000h, 32 Kbyte: addr[23:15]
`define MMD_XHIGH_PAGE 9'h01E

// ---------------------------------------------------------------
// Flash sector map
// ---------------------------------------------------------------
`define MMD_SEG_SMALL 8'h00
`define MMD_SEG_S4 8'h01
`define MMD_SEG_FIRST64 8'h02
`define MMD_SEG_LAST64 8'h08
`define MMD_SEC_S4 4'h4
`define MMD_SEC_BASE64 4'h3
`define MMD_SEC_TEN 4'hA
`define MMD_SEC_ELEVEN 4'hB
`define MMD_NUM_SECTORS 12

// ---------------------------------------------------------------
// Window compare granularity (4 Kbyte)
// ---------------------------------------------------------------
`define MMD_WIN_W 12
`define MMD_CFG_DEFAULT 3'h0

`endif

// File: test/mmd_decoder_assertions.sv
// Concurrent checks on the memory map decoder ports
`timescale 1ns/1ns
`include "mmd_defs.vh"

module mmd_decoder_assertions
(
  // Clock, reset and request
  input wire mclk_in,
  input wire rst_n_in,
  input wire cpu_req_in,
  input wire [23:0] cpu_addr_in,
  input wire cpu_stack_in,
  input wire cpu_bitop_in,
  input wire gpr_in,
  // Configuration
  input wire bootstrap_mode_in,
  input wire global_periph_bus_enable_in,
  input wire low_ext_ram_enable_in,
  input wire high_ext_ram_enable_in,
  input wire flash_ctrl_window_enable_in,
  // Target side
  input wire tgt_valid_out,
  input wire [2:0] tgt_sel_out,
  input wire [23:0] tgt_addr_out,
  input wire tgt_demux16_out,
  input wire pe_enable_out,
  input wire xram_misuse_out
);
  wire lo_on = global_periph_bus_enable_in && low_ext_ram_enable_in;
  wire hi_on = global_periph_bus_enable_in && high_ext_ram_enable_in;

  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Plain access: no stack, bit or bank use that could be refused
  sequence s_req;
    cpu_req_in && !gpr_in && !cpu_stack_in && !cpu_bitop_in;
  endsequence

  AST_ANSWER: assert property (cpu_req_in |=> tgt_valid_out != xram_misuse_out)
    else $error("request without exactly one answer");
  AST_COPY: assert property (s_req ##1 tgt_valid_out |->
    tgt_addr_out == $past(cpu_addr_in))
    else $error("address not forwarded unchanged");
  AST_BOOT: assert property (s_req ##0 bootstrap_mode_in &&
    cpu_addr_in[23:12] == 12'h000 |=> tgt_sel_out == `MMD_TGT_TEST)
    else $error("test sector not mapped in bootstrap");
  AST_FREG: assert property (s_req ##0 cpu_addr_in[23:16] == 8'h0E
    |=> tgt_sel_out == ($past(flash_ctrl_window_enable_in) ? `MMD_TGT_FREG : `MMD_TGT_EXT))
    else $error("control window steering wrong");
  AST_XLOW: assert property (s_req ##0 cpu_addr_in[23:11] == 13'h001C
    |=> tgt_sel_out == ($past(lo_on) ? `MMD_TGT_XLOW : `MMD_TGT_EXT))
    else $error("low area steering wrong");
  AST_XHIGH: assert property (s_req ##0 cpu_addr_in[23:15] == 9'h01E
    |=> tgt_sel_out == ($past(hi_on) ? `MMD_TGT_XHIGH : `MMD_TGT_EXT))
    else $error("high area steering wrong");
  AST_MISUSE: assert property (cpu_req_in && cpu_stack_in && !gpr_in && lo_on &&
    cpu_addr_in[23:11] == 13'h001C |=> xram_misuse_out && !tgt_valid_out)
    else $error("stack access to extension RAM not refused");
  AST_DEMUX: assert property (tgt_valid_out |-> tgt_demux16_out ==
    (tgt_sel_out == 3'h2 || tgt_sel_out == 3'h4 || tgt_sel_out == 3'h5))
    else $error("demux flag wrong for target");
  // Skip the first edge after release: the output still holds its reset value
  AST_PE: assert property ($past(rst_n_in) |->
    pe_enable_out == $past(flash_ctrl_window_enable_in))
    else $error("erase enable does not follow window enable");
endmodule

bind mmd_decoder mmd_decoder_assertions u_mmd_decoder_assertions
(
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cpu_req_in(cpu_req_in),
  .cpu_addr_in(cpu_addr_in), .cpu_stack_in(cpu_stack_in), .cpu_bitop_in(cpu_bitop_in),
  .gpr_in(gpr_in), .bootstrap_mode_in(bootstrap_mode_in),
  .global_periph_bus_enable_in(global_periph_bus_enable_in),
  .low_ext_ram_enable_in(low_ext_ram_enable_in),
  .high_ext_ram_enable_in(high_ext_ram_enable_in),
  .flash_ctrl_window_enable_in(flash_ctrl_window_enable_in),
  .tgt_valid_out(tgt_valid_out), .tgt_sel_out(tgt_sel_out), .tgt_addr_out(tgt_addr_out),
  .tgt_demux16_out(tgt_demux16_out), .pe_enable_out(pe_enable_out),
  .xram_misuse_out(xram_misuse_out)
);

// File: test/mmd_decoder_tb.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ns
`include "mmd_defs.vh"

module mmd_decoder_tb;
  reg mclk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg req, wr, byt, stk, bop, g, boot, gen, len, hen, fen, busy;
  reg [23:0] addr, ctx, b, s;
  reg [11:0] stat;
  reg [3:0] wen, idx;
  reg [47:0] wlo;
  wire v, tw, tb, dm, ba, bs, pe, rw, m;
  wire [2:0] sel, cfg;
  wire [23:0] ta;
  wire [15:0] twd;
  wire [3:0] sec;
  wire [1:0] sbs;
  wire [27:0] last;
  integer errors = 0;
  integer checks = 0;
  integer i;

  always #4 mclk_in = ~mclk_in;

  mmd_decoder u_mmd_decoder
  (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cpu_req_in(req), .cpu_addr_in(addr),
    .cpu_wr_in(wr), .cpu_byte_in(byt), .cpu_fetch_in(1'b0), .cpu_stack_in(stk),
    .cpu_bitop_in(bop), .cpu_wdata_in(addr[15:0]), .gpr_in(g), .gpr_idx_in(idx),
    .ctx_ptr_in(ctx), .bootstrap_mode_in(boot), .global_periph_bus_enable_in(gen),
    .low_ext_ram_enable_in(len), .high_ext_ram_enable_in(hen),
    .flash_ctrl_window_enable_in(fen), .flash_write_busy_in(busy),
    .flash_sector_status_in(stat), .win_en_in(wen), .win_lo_in(wlo), .win_hi_in(wlo),
    .tgt_valid_out(v), .tgt_sel_out(sel), .tgt_addr_out(ta), .tgt_wr_out(tw),
    .tgt_byte_out(tb), .tgt_wdata_out(twd), .tgt_demux16_out(dm), .sector_out(sec),
    .bank1_alias_out(ba), .bank1_sector_out(bs), .ext_cfg_set_out(cfg),
    .pe_enable_out(pe), .second_bank_status_out(sbs), .rww_violation_out(rw),
    .xram_misuse_out(m)
  );

  mmd_ext_mem u_mmd_ext_mem
  (
    .mclk_in(mclk_in), .tgt_valid_in(v), .tgt_sel_in(sel), .tgt_addr_in(ta),
    .tgt_byte_in(tb), .cfg_set_in(cfg), .last_out(last)
  );

  task chk(input [47:0] got, input [47:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  // One access; size toggles every call, so accesses alternate between byte and word
  task acc(input [23:0] a, input [2:0] e);
  begin
    @(negedge mclk_in);
    req = 1'b1;
    addr = a;
    byt = ~byt;
    @(negedge mclk_in);
    req = 0;
    if (e == `MMD_TGT_NONE)
      chk({m, v}, 2'b10);
    else
      chk({m, v, sel, tw, tb, ta, twd}, {2'b01, e, wr, byt, a, a[15:0]});
  end
  endtask

  // The model captures one edge after the answer
  task lastchk(input [2:0] c);
  begin
    @(negedge mclk_in);
    chk(last, {byt, c, addr});
  end
  endtask

  task t_boot;
  begin
    boot = 1'b1;
    acc(24'h000FFE, `MMD_TGT_TEST);
    acc(24'h001000, `MMD_TGT_FLASH);
    busy = 1'b1;
    acc(24'h000010, `MMD_TGT_TEST);
    chk(rw, 1'b1);
    boot = 1'b0;
    acc(24'h000010, `MMD_TGT_FLASH);
    wr = 1'b1;
    acc(24'h000012, `MMD_TGT_FLASH);
    chk(rw, 1'b0);
    wr = 1'b0;
    busy = 1'b0;
  end
  endtask

  task t_sect;
  begin
    for (i = 0; i < 12; i = i + 1)
    begin
      b = (i < 4) ? i * 24'h2000 : (i == 4) ? 24'h018000 : (i - 3) * 24'h10000;
      s = (i < 4) ? 24'h2000 : (i == 4) ? 24'h8000 : 24'h10000;
      acc(b, `MMD_TGT_FLASH);
      chk(sec, i[3:0]);
      acc(b + s - 24'h1, `MMD_TGT_FLASH);
      chk({ba, sec}, {i > 9, i[3:0]});
      if (i > 9)
        chk(bs, i == 11);
    end
    acc(24'h008000, `MMD_TGT_EXT);
    stat = 12'h400;
    @(negedge mclk_in);
    chk(sbs, 2'b01);
  end
  endtask

  task t_freg;
  begin
    fen = 1'b1;
    acc(24'h0E0010, `MMD_TGT_FREG);
    chk({dm, pe}, 2'b11);
    fen = 1'b0;
    acc(24'h0EFFFF, `MMD_TGT_EXT);
    chk({dm, pe}, 2'b00);
    acc(24'h00F7FE, `MMD_TGT_INTERNAL_DUAL_PORT_RAM);
    wr = 1'b1;
    acc(24'hFFFFFF, `MMD_TGT_EXT);
    lastchk(3'h0);
    wr = 1'b0;
  end
  endtask

  task t_xram;
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      gen = i[0];
      len = i[1];
      hen = i[1];
      acc(24'h00E7FE, (i == 3) ? `MMD_TGT_XLOW : `MMD_TGT_EXT);
      if (i != 3)
        lastchk(3'h1);
      acc(24'h0F7FFE, (i == 3) ? `MMD_TGT_XHIGH : `MMD_TGT_EXT);
      chk(dm, i == 3);
    end
    stk = 1'b1;
    acc(24'h00E010, `MMD_TGT_NONE);
    acc(24'h00F000, `MMD_TGT_INTERNAL_DUAL_PORT_RAM);
    stk = 1'b0;
    bop = 1'b1;
    acc(24'h0F0002, `MMD_TGT_NONE);
    bop = 1'b0;
    g = 1'b1;
    acc(24'h000000, `MMD_TGT_NONE);
    // Bank in internal RAM: size flips inside acc, word index 3 is 6 bytes up
    ctx = 24'h00F000;
    acc(byt ? 24'h00F006 : 24'h00F003, `MMD_TGT_INTERNAL_DUAL_PORT_RAM);
    acc(byt ? 24'h00F006 : 24'h00F003, `MMD_TGT_INTERNAL_DUAL_PORT_RAM);
    g = 1'b0;
  end
  endtask

  task final_report;
  begin
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  initial
  begin
    {req, wr, byt, stk, bop, g, boot, gen, len, hen, fen, busy} = 12'h000;
    addr = 24'h000000;
    ctx = 24'h00E000;
    idx = 4'h3;
    stat = 12'h000;
    // Two windows share page 00E so the lowest one must win
    wen = 4'h3;
    wlo = {24'h000000, 12'h00E, 12'h00E};
    repeat (6) @(negedge mclk_in);
    chk({v, sel}, 4'h7);
    rst_n_in = 1'b1;
    t_boot;
    t_sect;
    t_freg;
    t_xram;
    final_report;
  end
endmodule

// File: test/mmd_ext_mem.sv
// External memory interface model recording forwarded accesses
`timescale 1ns/1ns
`include "mmd_defs.vh"

module mmd_ext_mem
(
  // Decoder target side
  input wire mclk_in,
  input wire tgt_valid_in,
  input wire [2:0] tgt_sel_in,
  input wire [23:0] tgt_addr_in,
  input wire tgt_byte_in,
  input wire [2:0] cfg_set_in,
  // Last external access: size, bus set, address
  output reg [27:0] last_out
);
  always @(posedge mclk_in)
    if (tgt_valid_in && tgt_sel_in == `MMD_TGT_EXT)
      last_out <= {tgt_byte_in, cfg_set_in, tgt_addr_in};
endmodule
